// >>> icg_params.svh
// Notes on behaviour
// (RULE1) glue logic makes acknowledge and read strobe
// (RULE2) glue logic waits processor until vector valid
// (RULE3) at least 130 ns acknowledge-to-read gap
// (RULE4) under-service flags cleared by software command
// (RULE5) acknowledge shifter stays cleared outside acknowledge
// (RULE6) peripheral strobes follow system read/write strobes
// (RULE7) processor signals acknowledge via fetch plus I/O
// (RULE8) early detect: fetch without memory request
// (RULE9) acknowledge asserted at second bus state
// (RULE10) vector driven only under acknowledge plus read
// (RULE11) later shifter tap adds whole-cycle delay
// (RULE12) read and write low together resets
// (RULE13) status zero after reset reads 01xxx100b
// (RULE14) status bits 5,4,3 follow cts, sync, carrier
// (RULE15) processor fetch export and compat bits cleared
// (RULE16) three memory wait states, no I/O wait
// (RULE17) acknowledge read drives vector, sets under-service
// (RULE18) shifter clocked by processor clock, cleared asynchronously
`ifndef ICG_PARAMS_SVH
`define ICG_PARAMS_SVH

// register offsets on the two address pins
`define ICG_OFS_CMD        2'h0
`define ICG_OFS_VECTOR     2'h1
`define ICG_OFS_EXT_ENABLE 2'h2

// status zero field positions
`define ICG_ST_CTS_BIT     5
`define ICG_ST_SYNC_BIT    4
`define ICG_ST_DCD_BIT     3
`define ICG_ST_FIXED_MASK  8'h44

// external enable field positions
`define ICG_EN_CTS_BIT     5
`define ICG_EN_SYNC_BIT    4
`define ICG_EN_DCD_BIT     3
`define ICG_EN_MASTER_BIT  0

// command codes
`define ICG_CMD_RST_EXT    8'h10
`define ICG_CMD_RST_IUS    8'h38

// reset values
`define ICG_VECTOR_RESET   8'h00
`define ICG_ENABLE_RESET   8'h00
`define ICG_PINS_IDLE      18'h3C000

`endif

// >>> icg_pkg.sv
package icg_pkg;

  typedef struct packed {
    logic       rd_n;
    logic       wr_n;
    logic       cs_n;
    logic       ack_n;
    logic [1:0] addr;
    logic [7:0] data;
    logic       cts;
    logic       syn;
    logic       dcd;
    logic       iei;
  } icg_pins_t;

  typedef enum logic [1:0] {
    ICG_IDLE  = 2'b00,
    ICG_READ  = 2'b01,
    ICG_ACK   = 2'b11,
    ICG_WRITE = 2'b10
  } icg_state_t;

  typedef struct packed {
    logic [7:0] vector;
    logic [7:0] enable;
    logic [2:0] prev_in;
    logic       ip;
    logic       ius;
  } icg_ctrl_t;

endpackage : icg_pkg

// >>> icg_irq_acknowledge_n_port.sv
`timescale 1ns/10ps
`include "icg_params.svh"

module icg_irq_acknowledge_n_port
  import icg_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              resetn,
  // bus strobes and select
  input  wire logic              periph_read_strobe_n,
  input  wire logic              periph_write_strobe_n,
  input  wire logic              chip_select_n,
  input  wire logic              irq_acknowledge_n,
  input  wire logic [1:0]        reg_addr,
  // data bus, three-signal form
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe_n,
  // modem status inputs
  input  wire logic              cts_in,
  input  wire logic              sync_in,
  input  wire logic              carrier_detect_in,
  // priority chain and request
  input  wire logic              chain_enable_in,
  output logic                   chain_enable_out,
  output logic                   irq_request_n
);

  if (DATA_W != 8) begin : g_width_check
    $error("icg_irq_acknowledge_n_port serves only an 8-bit data bus");
  end

  icg_pins_t  pins;
  icg_pins_t  s1;
  icg_pins_t  s2;
  icg_pins_t  s3;
  icg_pins_t  filt;
  icg_pins_t  next_filt;
  icg_state_t state;
  icg_state_t next_state;
  icg_ctrl_t  ctrl;
  icg_ctrl_t  next_ctrl;
  logic [7:0] next_data_out;
  logic       next_data_oe_n;
  logic       hw_rst;
  logic       ack_req;
  logic       rd_req;
  logic       wr_req;
  logic       win;
  logic [2:0] cur_in;
  logic [2:0] ev;

  function automatic logic [7:0] status_word(input logic cts, input logic syn,
                                             input logic dcd);
    logic [7:0] w;
    w                   = `ICG_ST_FIXED_MASK; // RULE13
    w[`ICG_ST_CTS_BIT]  = cts;
    w[`ICG_ST_SYNC_BIT] = syn;
    w[`ICG_ST_DCD_BIT]  = dcd;
    return w;
  endfunction : status_word

  assign pins = '{rd_n: periph_read_strobe_n, wr_n: periph_write_strobe_n,
                  cs_n: chip_select_n, ack_n: irq_acknowledge_n, addr: reg_addr,
                  data: data_in, cts: cts_in, syn: sync_in,
                  dcd: carrier_detect_in, iei: chain_enable_in};

  // input filter: change taken when stages two and three agree
  always_comb begin
    next_filt = icg_pins_t'((s2 & s3) | (filt & (s2 | s3)));
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s1   <= icg_pins_t'(`ICG_PINS_IDLE);
      s2   <= icg_pins_t'(`ICG_PINS_IDLE);
      s3   <= icg_pins_t'(`ICG_PINS_IDLE);
      filt <= icg_pins_t'(`ICG_PINS_IDLE);
    end else begin
      s1   <= pins;
      s2   <= s1;
      s3   <= s2;
      filt <= next_filt;
    end
  end

  assign hw_rst  = !filt.rd_n && !filt.wr_n;
  assign ack_req = !filt.ack_n && !filt.rd_n;
  assign rd_req  = !filt.cs_n && !filt.rd_n && filt.ack_n;
  assign wr_req  = !filt.cs_n && !filt.wr_n;
  assign win     = filt.iei && ctrl.ip && !ctrl.ius;
  assign cur_in  = {filt.cts, filt.syn, filt.dcd};
  assign ev      = (cur_in ^ ctrl.prev_in) & {ctrl.enable[`ICG_EN_CTS_BIT],
                   ctrl.enable[`ICG_EN_SYNC_BIT], ctrl.enable[`ICG_EN_DCD_BIT]};

  // access sequencer and control state
  always_comb begin
    next_state     = state;
    next_ctrl      = ctrl;
    next_data_out  = data_out;
    next_data_oe_n = data_oe_n;
    next_ctrl.prev_in = cur_in;
    unique case (state)
      ICG_IDLE: begin
        if (ack_req) begin
          next_state = ICG_ACK;
          if (win) begin
            next_data_out  = ctrl.vector; // RULE17
            next_data_oe_n = 1'b0; // RULE10
            next_ctrl.ius  = 1'b1; // RULE17
          end
        end else if (rd_req) begin
          next_state     = ICG_READ;
          next_data_oe_n = 1'b0;
          if (filt.addr == `ICG_OFS_VECTOR) begin
            next_data_out = ctrl.vector;
          end else if (filt.addr == `ICG_OFS_EXT_ENABLE) begin
            next_data_out = ctrl.enable;
          end else begin
            next_data_out = status_word(filt.cts, filt.syn, filt.dcd); // RULE14
          end
        end else if (wr_req) begin
          next_state = ICG_WRITE;
          if (filt.addr == `ICG_OFS_VECTOR) begin
            next_ctrl.vector = filt.data;
          end else if (filt.addr == `ICG_OFS_EXT_ENABLE) begin
            next_ctrl.enable = filt.data;
          end else if (filt.data == `ICG_CMD_RST_EXT) begin
            next_ctrl.ip = 1'b0;
          end else if (filt.data == `ICG_CMD_RST_IUS) begin
            next_ctrl.ius = 1'b0; // RULE4
          end
        end
      end
      ICG_READ: begin
        if (filt.rd_n || filt.cs_n) begin
          next_state     = ICG_IDLE;
          next_data_oe_n = 1'b1;
        end
      end
      ICG_ACK: begin
        if (!ack_req) begin
          next_state     = ICG_IDLE;
          next_data_oe_n = 1'b1; // RULE10
        end
      end
      ICG_WRITE: begin
        if (!wr_req) begin
          next_state = ICG_IDLE;
        end
      end
    endcase
    // status change event wins over its clear
    if (|ev) begin
      next_ctrl.ip = 1'b1; // RULE4
    end
    if (hw_rst) begin
      next_state       = ICG_IDLE; // RULE12
      next_data_oe_n   = 1'b1;
      next_ctrl.vector = `ICG_VECTOR_RESET;
      next_ctrl.enable = `ICG_ENABLE_RESET;
      next_ctrl.ip     = 1'b0;
      next_ctrl.ius    = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state     <= ICG_IDLE;
      ctrl      <= '{vector: `ICG_VECTOR_RESET, enable: `ICG_ENABLE_RESET,
                     prev_in: 3'h0, ip: 1'b0, ius: 1'b0};
      data_out  <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      state     <= next_state;
      ctrl      <= next_ctrl;
      data_out  <= next_data_out;
      data_oe_n <= next_data_oe_n;
    end
  end

  // priority chain pass-through and request
  assign chain_enable_out = filt.iei && !ctrl.ius && !(!filt.ack_n && ctrl.ip);
  assign irq_request_n    = !(ctrl.ip && !ctrl.ius && ctrl.enable[`ICG_EN_MASTER_BIT]);

  hw_reset_clear_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE12
    hw_rst |=> (ctrl.vector == `ICG_VECTOR_RESET && ctrl.enable == `ICG_ENABLE_RESET
                && !ctrl.ius && data_oe_n && state == ICG_IDLE))
    else $error("hardware reset did not clear control state");

  stat_fixed_bits_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE13
    (state == ICG_IDLE && !ack_req && rd_req && !hw_rst && filt.addr == `ICG_OFS_CMD)
    |=> (data_out[7] == 1'b0 && data_out[6] == 1'b1 && data_out[2:0] == 3'b100
         && !data_oe_n))
    else $error("status zero fixed bits wrong");

  stat_input_bits_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE14
    (state == ICG_IDLE && !ack_req && rd_req && !hw_rst && filt.addr == `ICG_OFS_CMD)
    |=> data_out[5:3] == $past(cur_in))
    else $error("status zero input bits do not follow pins");

  vec_drive_gate_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE10
    (state == ICG_ACK && !data_oe_n) |-> $past(!filt.ack_n && !filt.rd_n))
    else $error("vector driven without acknowledge and read");

  ack_release_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE10
    (state == ICG_ACK && !ack_req) |=> (data_oe_n && state == ICG_IDLE))
    else $error("vector not released at end of acknowledge");

  ack_win_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE17
    (state == ICG_IDLE && ack_req && win && !hw_rst)
    |=> (ctrl.ius && !data_oe_n && data_out == $past(ctrl.vector)))
    else $error("winning acknowledge did not drive vector");

  ack_lose_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE10
    (state == ICG_IDLE && ack_req && !win) |=> data_oe_n [*2])
    else $error("losing device drove the bus");

  ius_cmd_clear_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE4
    (state == ICG_IDLE && !ack_req && !rd_req && wr_req
     && filt.addr == `ICG_OFS_CMD && filt.data == `ICG_CMD_RST_IUS) |=> !ctrl.ius)
    else $error("under-service flag not cleared by command");

  ip_set_wins_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE4
    ((|ev) && !hw_rst) |=> ctrl.ip)
    else $error("status change event lost");

endmodule : icg_irq_acknowledge_n_port

// >>> icg_host_model.sv
`timescale 1ns/10ps
module icg_host_model
  import icg_pkg::*;
(
  // clock
  input  wire logic       mclk,
  // device drive seen
  input  wire logic       data_oe_n,
  input  wire logic [7:0] data_out,
  // strobes and bus
  output logic            rd_n,
  output logic            wr_n,
  output logic            cs_n,
  output logic            ack_n,
  output logic [1:0]      addr,
  output logic [7:0]      bus
);
  localparam int         RD_TAP                  = 14;
  localparam int         WAIT_TAP                = 22;
  localparam logic       fetch_strobe_export_bit = 1'b0;
  localparam logic       io_compat_bit           = 1'b0;
  localparam logic [7:0] dma_wait_ctrl_reg       = 8'hC0;
  logic                  drv;
  logic [7:0]            hd;
  logic [7:0]            pat;
  logic                  sys_rd_n;
  logic                  sys_wr_n;
  logic                  opcode_fetch_strobe_n;
  logic                  memory_request_n;
  logic                  io_request_n;
  logic                  wait_n;
  logic [WAIT_TAP:0]     ack_shift;
  initial begin
    {sys_rd_n, sys_wr_n, cs_n, drv} = 4'hE;
    {opcode_fetch_strobe_n, memory_request_n, io_request_n} = 3'h7;
    addr = 2'h0;
    hd = 8'h00;
    pat = 8'h5A;
  end
  // released bus never keeps its last value
  always @(posedge mclk) pat <= ~pat;
  assign bus = drv ? hd : (!data_oe_n ? data_out : pat);
  // acknowledge shifter, cleared while the fetch strobe is inactive
  always @(posedge mclk or posedge opcode_fetch_strobe_n) begin
    if (opcode_fetch_strobe_n) ack_shift <= '0;
    else ack_shift <= {ack_shift[WAIT_TAP-1:0], memory_request_n};
  end
  assign ack_n  = !ack_shift[0];
  assign rd_n   = sys_rd_n && !ack_shift[RD_TAP];
  assign wr_n   = sys_wr_n;
  assign wait_n = !(ack_shift[0] && !ack_shift[WAIT_TAP]);
  task automatic go(input logic [1:0] a, input logic w, input logic [7:0] d,
                    output logic [7:0] q);
    @(posedge mclk);
    cs_n <= 1'b0;
    sys_rd_n <= w;
    sys_wr_n <= !w;
    addr <= a;
    hd <= d;
    drv <= w;
    repeat (dma_wait_ctrl_reg[5:4]) @(posedge mclk);
    for (int i = 0; i < 12 && (w || data_oe_n !== 1'b0); i++) @(posedge mclk);
    q = bus;
    {cs_n, sys_rd_n, sys_wr_n, drv} <= 4'hE;
    repeat (8) @(posedge mclk);
  endtask : go
  task automatic hw_rst();
    @(posedge mclk);
    {sys_rd_n, sys_wr_n} <= 2'h0;
    repeat (6) @(posedge mclk);
    {sys_rd_n, sys_wr_n} <= 2'h3;
    repeat (8) @(posedge mclk);
  endtask : hw_rst
  // ordinary opcode fetch: memory request active, no acknowledge
  task automatic fetch(output logic hit);
    hit = 1'b0;
    @(posedge mclk);
    opcode_fetch_strobe_n <= fetch_strobe_export_bit;
    memory_request_n      <= 1'b0;
    repeat (4) begin
      @(posedge mclk);
      hit = hit | !ack_n;
    end
    {opcode_fetch_strobe_n, memory_request_n} <= 2'h3;
    repeat (4) @(posedge mclk);
  endtask : fetch
  task automatic ack(output logic dr, output logic [7:0] q);
    @(posedge mclk);
    opcode_fetch_strobe_n <= fetch_strobe_export_bit;
    repeat (io_compat_bit ? 1 : 2) @(posedge mclk);
    io_request_n <= 1'b0;
    for (int i = 0; i < 40 && wait_n !== 1'b1; i++) @(posedge mclk);
    dr = (data_oe_n === 1'b0);
    q = bus;
    {opcode_fetch_strobe_n, io_request_n} <= 2'h3;
    repeat (8) @(posedge mclk);
  endtask : ack
endmodule : icg_host_model

// >>> testbench.sv
`timescale 1ns/10ps
module testbench
  import icg_pkg::*;
;
  logic       mclk, resetn, cts, syn, dcd, iei, rd_n, wr_n, cs_n, ack_n;
  logic       oe_n, ieo, irq_n, dr;
  logic [1:0] addr;
  logic [7:0] bus, dout, q;
  int         mismatches, total_checks, cyc, seed, m_vec, m_en, m_pend, m_ius;
  icg_irq_acknowledge_n_port DUT (.mclk(mclk), .resetn(resetn), .periph_read_strobe_n(rd_n),
    .periph_write_strobe_n(wr_n), .chip_select_n(cs_n), .irq_acknowledge_n(ack_n),
    .reg_addr(addr), .data_in(bus), .data_out(dout), .data_oe_n(oe_n), .cts_in(cts),
    .sync_in(syn), .carrier_detect_in(dcd), .chain_enable_in(iei),
    .chain_enable_out(ieo), .irq_request_n(irq_n));
  icg_host_model host (.mclk(mclk), .data_oe_n(oe_n), .data_out(dout), .rd_n(rd_n),
    .wr_n(wr_n), .cs_n(cs_n), .ack_n(ack_n), .addr(addr), .bus(bus));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  function automatic logic [7:0] st();
    return {2'b01, cts, syn, dcd, 3'b100};
  endfunction : st
  function automatic logic [7:0] xirq();
    return {7'h00, !(m_pend != 0 && m_ius == 0 && m_en[0])};
  endfunction : xirq
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    seed = 32'h40ad8ccd;
    {resetn, cts, syn, dcd, iei} = 5'h01;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    host.hw_rst();
    m_vec = 0;
    m_en = 0;
    m_pend = 0;
    m_ius = 0;
    for (int i = 0; i < 4; i++) begin
      {cts, syn, dcd} <= 3'($random(seed));
      repeat (6) @(posedge mclk);
      host.go(2'h0, 1'b0, 8'h00, q);
      check("status", q, st());
    end
    host.go(2'h3, 1'b1, 8'hFF, q);
    host.go(2'h3, 1'b0, 8'h00, q);
    check("status_alias", q, st());
    m_vec = $random(seed) & 255;
    host.go(2'h1, 1'b1, m_vec[7:0], q);
    host.go(2'h1, 1'b0, 8'h00, q);
    check("vector", q, m_vec[7:0]);
    m_en = 8'h21;
    host.go(2'h2, 1'b1, 8'h21, q);
    host.go(2'h2, 1'b0, 8'h00, q);
    check("enable", q, 8'h21);
    check("irq_idle", {7'h00, irq_n}, xirq());
    cts <= !cts;
    m_pend = 1;
    repeat (8) @(posedge mclk);
    check("irq_set", {7'h00, irq_n}, xirq());
    host.fetch(dr);
    check("mem_fetch", {7'h00, dr}, 8'h00);
    check("fetch_quiet", {7'h00, oe_n}, 8'h01);
    iei <= 1'b0;
    repeat (6) @(posedge mclk);
    host.ack(dr, q);
    check("blocked", {7'h00, dr}, 8'h00);
    iei <= 1'b1;
    repeat (6) @(posedge mclk);
    check("chain_idle", {7'h00, ieo}, 8'h01);
    host.ack(dr, q);
    m_ius = 1;
    check("ack_drive", {7'h00, dr}, 8'h01);
    check("ack_vector", q, m_vec[7:0]);
    check("irq_serv", {7'h00, irq_n}, xirq());
    check("chain_serv", {7'h00, ieo}, 8'h00);
    host.go(2'h0, 1'b1, 8'h10, q);
    m_pend = 0;
    host.go(2'h0, 1'b1, 8'h38, q);
    m_ius = 0;
    check("irq_clr", {7'h00, irq_n}, xirq());
    check("chain_clr", {7'h00, ieo}, 8'h01);
    host.ack(dr, q);
    check("no_pend", {7'h00, dr}, 8'h00);
    host.hw_rst();
    host.go(2'h1, 1'b0, 8'h00, q);
    check("vector_rst", q, 8'h00);
    close_out();
  end
endmodule : testbench
